// *** pce_pkg.sv ***
// How it works
// - Eight comparison units each compare their own value with the channel 0 counter.
// - A unit matches only while enabled and the counter equals its value.
// - Center-aligned counting uses the direction bit; left-aligned ignores it.
// - An active channel 0 fault blocks every comparison match.
// - Per-unit period counter wraps at its maximum; compare only when it equals trigger.
// - Maximum and trigger both zero means compare in every channel 0 period.
// - With channel 0 enabled, configuration and value change only through shadows.
// - Shadows move to active when the unit update counter reaches its update period.
// - The unit update period itself changes through the configuration shadow.
// - A value shadow write applies only after a configuration shadow write follows.
// - Match and update flags raise the interrupt when unmasked; status read clears.
// - Two independent event line outputs trigger other peripherals.
// - An event line pulses one clock when a selected comparison starts matching.
// - Period, duty and dead-time take direct writes only while the channel is off.
// - Duty resolution is one period-counter step of the programmed period.
// - Asynchronous channel shadows apply at the end of their current period.
// - Synchronous method 0 applies all shadows after unlock and period end.
// - Synchronous methods 1 and 2 apply period and dead-time after unlock.
// - Methods 1 and 2 apply duty when update count equals update period.
// - Several shadow writes between updates leave only the last value.
// - The unlock bit stays set until the synchronous update, then reads zero.
// - Automatic methods wait update period plus one periods, then apply duty.
package pce_pkg;
  localparam int N_CMP = 8;
  localparam int N_CH = 4;
  // Register byte offsets
  localparam logic [11:0] OFS_SYNC_MODE = 12'h020;
  localparam logic [11:0] OFS_UPD_CTRL = 12'h028;
  localparam logic [11:0] OFS_UPD_PER = 12'h02C;
  localparam logic [11:0] OFS_UPD_PER_SH = 12'h030;
  localparam logic [11:0] OFS_IRQ_EN = 12'h034;
  localparam logic [11:0] OFS_IRQ_DIS = 12'h038;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h03C;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h040;
  localparam logic [11:0] OFS_EVT0 = 12'h080;
  localparam logic [11:0] OFS_EVT1 = 12'h084;
  // Compare unit block: base + unit*16, four words each
  localparam logic [3:0] PAGE_CMP = 4'h1;
  localparam logic [3:0] PAGE_CH = 4'h3;
  localparam logic [1:0] CMP_CFG = 2'h0;
  localparam logic [1:0] CMP_VAL = 2'h1;
  localparam logic [1:0] CMP_CFG_SH = 2'h2;
  localparam logic [1:0] CMP_VAL_SH = 2'h3;
  // Channel block: base + ch*32, six words each
  localparam logic [2:0] CH_PER = 3'h0;
  localparam logic [2:0] CH_PER_SH = 3'h1;
  localparam logic [2:0] CH_DUTY = 3'h2;
  localparam logic [2:0] CH_DUTY_SH = 3'h3;
  localparam logic [2:0] CH_DT = 3'h4;
  localparam logic [2:0] CH_DT_SH = 3'h5;
  // Compare configuration fields
  localparam int CFG_EN = 0;
  localparam int CFG_TRIG = 8;
  localparam int CFG_PCNT = 12;
  localparam int CFG_PMAX = 16;
  localparam int CFG_UCNT = 20;
  localparam int CFG_UPER = 24;
  localparam logic [31:0] CFG_WMASK = 32'h0F0F_0F01;
  // Compare value fields
  localparam int VAL_DIR = 24;
  localparam logic [31:0] VAL_WMASK = 32'h0100_FFFF;
  // Sync mode fields
  localparam int SM_METHOD = 16;
  localparam logic [1:0] METHOD_MANUAL = 2'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef struct packed {
    logic [N_CMP-1:0][31:0] cfg;
    logic [N_CMP-1:0][31:0] val;
    logic [N_CMP-1:0][31:0] cfg_sh;
    logic [N_CMP-1:0][31:0] val_sh;
    logic [N_CMP-1:0][3:0] pcnt;
    logic [N_CMP-1:0][3:0] ucnt;
    logic [N_CMP-1:0] cfg_pend;
    logic [N_CMP-1:0] val_pend;
    logic [N_CMP-1:0] match_prev;
    logic [N_CMP-1:0] flag_match;
    logic [N_CMP-1:0] flag_upd;
    logic [15:0] mask;
    logic [1:0][N_CMP-1:0] ev_sel;
    logic [1:0] ev;
    logic [N_CH-1:0] sync;
    logic [1:0] method;
    logic unlock;
    logic [3:0] sync_update_period;
    logic [3:0] sync_update_count;
    logic [3:0] upr_sh;
    logic upr_pend;
    logic [N_CH-1:0][15:0] per;
    logic [N_CH-1:0][15:0] per_sh;
    logic [N_CH-1:0][15:0] duty;
    logic [N_CH-1:0][15:0] duty_sh;
    logic [N_CH-1:0][31:0] dt;
    logic [N_CH-1:0][31:0] dt_sh;
    logic [N_CH-1:0] per_pend;
    logic [N_CH-1:0] duty_pend;
    logic [N_CH-1:0] dt_pend;
    logic ack;
    logic [31:0] dat;
  } pce_state_t;
endpackage : pce_pkg

// *** pce_compare_update.sv ***
`timescale 1ns/1ps
module pce_compare_update (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Channel counters and status from the waveform logic
  input wire logic [15:0] counter0,
  input wire logic counter0_down,
  input wire logic alignment_center,
  input wire logic fault_ch0,
  input wire logic [pce_pkg::N_CH-1:0] channel_enabled,
  input wire logic [pce_pkg::N_CH-1:0] period_end,
  // Event lines and interrupt
  output logic [1:0] event_line,
  output logic irq,
  // Active waveform parameters
  output logic [pce_pkg::N_CH-1:0][15:0] period_active,
  output logic [pce_pkg::N_CH-1:0][15:0] duty_active,
  output logic [pce_pkg::N_CH-1:0][31:0] deadtime_active
);
  import pce_pkg::*;

  pce_state_t s_q;
  pce_state_t s_d;
  logic [N_CMP-1:0] match;
  logic [N_CMP-1:0] rise;
  logic [N_CMP-1:0] upd_evt;
  logic acc;
  logic wr;
  logic rd;
  logic upr_hit;
  logic lock_go;
  logic [2:0] unit;
  logic [1:0] chn;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Whole next-state computation
  always_comb
  begin
    s_d = s_q;
    acc = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = acc & wb_we_i;
    rd = acc & ~wb_we_i;
    unit = wb_adr_i[6:4];
    chn = wb_adr_i[6:5];
    upd_evt = '0;
    s_d.ack = acc;
    s_d.dat = RST_WORD;

    // Comparison units, all watching the shared channel 0 counter
    for (int i = 0; i < N_CMP; i++)
    begin
      match[i] = s_q.cfg[i][CFG_EN] & ~fault_ch0
                 & (counter0 == s_q.val[i][15:0])
                 & (s_q.pcnt[i] == s_q.cfg[i][CFG_TRIG +: 4])
                 & (~alignment_center | (s_q.val[i][VAL_DIR] == counter0_down));
    end
    // Edge detect so a counter held on the value gives one pulse only
    rise = match & ~s_q.match_prev;
    s_d.match_prev = match;
    for (int e = 0; e < 2; e++)
    begin
      s_d.ev[e] = |(rise & s_q.ev_sel[e]);
    end

    // Period and update counters step at each channel 0 period end
    if (period_end[0])
    begin
      for (int i = 0; i < N_CMP; i++)
      begin
        if (s_q.pcnt[i] == s_q.cfg[i][CFG_PMAX +: 4])
        begin
          s_d.pcnt[i] = 4'h0;
        end
        else
        begin
          s_d.pcnt[i] = s_q.pcnt[i] + 4'h1;
        end
        if (s_q.ucnt[i] == s_q.cfg[i][CFG_UPER +: 4])
        begin
          s_d.ucnt[i] = 4'h0;
          // Value waits for a configuration write before it may move
          if (s_q.cfg_pend[i])
          begin
            s_d.cfg[i] = s_q.cfg_sh[i];
            if (s_q.val_pend[i])
            begin
              s_d.val[i] = s_q.val_sh[i];
            end
            s_d.cfg_pend[i] = 1'b0;
            s_d.val_pend[i] = 1'b0;
            upd_evt[i] = 1'b1;
          end
        end
        else
        begin
          s_d.ucnt[i] = s_q.ucnt[i] + 4'h1;
        end
      end
    end

    // Synchronous channel update period counter, automatic methods only
    upr_hit = period_end[0] & (s_q.method != METHOD_MANUAL) & (s_q.sync_update_count == s_q.sync_update_period);
    lock_go = period_end[0] & s_q.unlock;
    if (period_end[0] && s_q.method != METHOD_MANUAL)
    begin
      s_d.sync_update_count = upr_hit ? 4'h0 : s_q.sync_update_count + 4'h1;
    end
    if (upr_hit && s_q.upr_pend)
    begin
      s_d.sync_update_period = s_q.upr_sh;
      s_d.upr_pend = 1'b0;
    end
    if (lock_go)
    begin
      s_d.unlock = 1'b0;
    end

    // Shadow transfer of period, duty and dead-time per channel
    for (int c = 0; c < N_CH; c++)
    begin
      logic go_pd;
      logic go_du;
      if (s_q.sync[c])
      begin
        go_pd = lock_go;
        go_du = (s_q.method == METHOD_MANUAL) ? lock_go : upr_hit;
      end
      else
      begin
        go_pd = period_end[c];
        go_du = period_end[c];
      end
      if (go_pd && s_q.per_pend[c])
      begin
        s_d.per[c] = s_q.per_sh[c];
        s_d.per_pend[c] = 1'b0;
      end
      if (go_pd && s_q.dt_pend[c])
      begin
        s_d.dt[c] = s_q.dt_sh[c];
        s_d.dt_pend[c] = 1'b0;
      end
      if (go_du && s_q.duty_pend[c])
      begin
        s_d.duty[c] = s_q.duty_sh[c];
        s_d.duty_pend[c] = 1'b0;
      end
    end

    // Bus writes; pending marks set here so a write beats a same-cycle transfer
    if (wr)
    begin
      if (wb_adr_i[11:8] == PAGE_CMP)
      begin
        case (wb_adr_i[3:2])
          // Direct writes only while channel 0 is stopped
          CMP_CFG:
          begin
            if (!channel_enabled[0])
            begin
              s_d.cfg[unit] = wmerge(s_q.cfg[unit], wb_dat_i, wb_sel_i) & CFG_WMASK;
            end
          end
          CMP_VAL:
          begin
            if (!channel_enabled[0])
            begin
              s_d.val[unit] = wmerge(s_q.val[unit], wb_dat_i, wb_sel_i) & VAL_WMASK;
            end
          end
          CMP_CFG_SH:
          begin
            s_d.cfg_sh[unit] = wmerge(s_q.cfg_sh[unit], wb_dat_i, wb_sel_i) & CFG_WMASK;
            s_d.cfg_pend[unit] = 1'b1;
          end
          default:
          begin
            s_d.val_sh[unit] = wmerge(s_q.val_sh[unit], wb_dat_i, wb_sel_i) & VAL_WMASK;
            s_d.val_pend[unit] = 1'b1;
          end
        endcase
      end
      else if (wb_adr_i[11:8] == PAGE_CH && wb_adr_i[4:2] <= CH_DT_SH)
      begin
        case (wb_adr_i[4:2])
          CH_PER:
          begin
            if (!channel_enabled[chn])
            begin
              s_d.per[chn] = 16'(wmerge(32'(s_q.per[chn]), wb_dat_i, wb_sel_i));
            end
          end
          CH_PER_SH:
          begin
            s_d.per_sh[chn] = 16'(wmerge(32'(s_q.per_sh[chn]), wb_dat_i, wb_sel_i));
            s_d.per_pend[chn] = 1'b1;
          end
          CH_DUTY:
          begin
            if (!channel_enabled[chn])
            begin
              s_d.duty[chn] = 16'(wmerge(32'(s_q.duty[chn]), wb_dat_i, wb_sel_i));
            end
          end
          CH_DUTY_SH:
          begin
            s_d.duty_sh[chn] = 16'(wmerge(32'(s_q.duty_sh[chn]), wb_dat_i, wb_sel_i));
            s_d.duty_pend[chn] = 1'b1;
          end
          CH_DT:
          begin
            if (!channel_enabled[chn])
            begin
              s_d.dt[chn] = wmerge(s_q.dt[chn], wb_dat_i, wb_sel_i);
            end
          end
          default:
          begin
            s_d.dt_sh[chn] = wmerge(s_q.dt_sh[chn], wb_dat_i, wb_sel_i);
            s_d.dt_pend[chn] = 1'b1;
          end
        endcase
      end
      else
      begin
        case (wb_adr_i)
          OFS_SYNC_MODE:
          begin
            s_d.sync = wb_dat_i[N_CH-1:0];
            s_d.method = wb_dat_i[SM_METHOD +: 2];
          end
          OFS_UPD_CTRL:
          begin
            if (wb_dat_i[0])
            begin
              s_d.unlock = 1'b1;
            end
          end
          OFS_UPD_PER: s_d.sync_update_period = wb_dat_i[3:0];
          OFS_UPD_PER_SH:
          begin
            s_d.upr_sh = wb_dat_i[3:0];
            s_d.upr_pend = 1'b1;
          end
          OFS_IRQ_EN: s_d.mask = s_q.mask | wb_dat_i[15:0];
          OFS_IRQ_DIS: s_d.mask = s_q.mask & ~wb_dat_i[15:0];
          OFS_EVT0: s_d.ev_sel[0] = wb_dat_i[N_CMP-1:0];
          OFS_EVT1: s_d.ev_sel[1] = wb_dat_i[N_CMP-1:0];
          default: s_d.mask = s_q.mask;
        endcase
      end
    end

    // Read mux; unmapped addresses read zero
    if (rd)
    begin
      if (wb_adr_i[11:8] == PAGE_CMP)
      begin
        case (wb_adr_i[3:2])
          CMP_CFG:
          begin
            s_d.dat = s_q.cfg[unit];
            s_d.dat[CFG_PCNT +: 4] = s_q.pcnt[unit];
            s_d.dat[CFG_UCNT +: 4] = s_q.ucnt[unit];
          end
          CMP_VAL: s_d.dat = s_q.val[unit];
          default: s_d.dat = RST_WORD;
        endcase
      end
      else if (wb_adr_i[11:8] == PAGE_CH)
      begin
        case (wb_adr_i[4:2])
          CH_PER: s_d.dat = {16'h0000, s_q.per[chn]};
          CH_DUTY: s_d.dat = {16'h0000, s_q.duty[chn]};
          CH_DT: s_d.dat = s_q.dt[chn];
          default: s_d.dat = RST_WORD;
        endcase
      end
      else
      begin
        case (wb_adr_i)
          OFS_SYNC_MODE: s_d.dat = {14'h0000, s_q.method, 12'h000, s_q.sync};
          OFS_UPD_CTRL: s_d.dat = {31'h0000_0000, s_q.unlock};
          OFS_UPD_PER: s_d.dat = {24'h00_0000, s_q.sync_update_count, s_q.sync_update_period};
          OFS_IRQ_MASK: s_d.dat = {16'h0000, s_q.mask};
          OFS_IRQ_STAT:
          begin
            s_d.dat = {16'h0000, s_q.flag_upd, s_q.flag_match};
            s_d.flag_match = '0;
            s_d.flag_upd = '0;
          end
          OFS_EVT0: s_d.dat = {24'h00_0000, s_q.ev_sel[0]};
          OFS_EVT1: s_d.dat = {24'h00_0000, s_q.ev_sel[1]};
          default: s_d.dat = RST_WORD;
        endcase
      end
    end

    // New events win over a same-cycle read clear
    s_d.flag_match = s_d.flag_match | rise;
    s_d.flag_upd = s_d.flag_upd | upd_evt;
  end

  // State register; synchronous reset clears everything
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flops
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign event_line = s_q.ev;
  assign irq = |({s_q.flag_upd, s_q.flag_match} & s_q.mask);
  assign period_active = s_q.per;
  assign duty_active = s_q.duty;
  assign deadtime_active = s_q.dt;

  // Event pulse lasts exactly one clock
  property p_event_one_cycle;
    @(posedge clk) disable iff (reset)
    event_line[0] |=> !event_line[0];
  endproperty
  a_event_one_cycle: assert property (p_event_one_cycle)
    else $error("event line 0 wider than one cycle");

  // Event pulse needs a selected unit that just began matching
  property p_event_cause;
    @(posedge clk) disable iff (reset)
    $rose(event_line[1]) |-> $past(|(rise & s_q.ev_sel[1]));
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("event line 1 pulsed without a selected match");

  // No match while channel 0 is in fault
  property p_fault_blocks;
    @(posedge clk) disable iff (reset)
    fault_ch0 |-> (match == '0);
  endproperty
  a_fault_blocks: assert property (p_fault_blocks)
    else $error("comparison matched during fault");

  // Match of unit 0 implies enable and counter equality
  property p_match_cause;
    @(posedge clk) disable iff (reset)
    match[0] |-> (s_q.cfg[0][CFG_EN] && counter0 == s_q.val[0][15:0]);
  endproperty
  a_match_cause: assert property (p_match_cause)
    else $error("unit 0 matched while disabled or off value");

  // Unlock clears at the next synchronous period end unless rewritten
  property p_unlock_clear;
    @(posedge clk) disable iff (reset)
    (s_q.unlock && period_end[0] && !(wr && wb_adr_i == OFS_UPD_CTRL)) |=> !s_q.unlock;
  endproperty
  a_unlock_clear: assert property (p_unlock_clear)
    else $error("unlock bit not cleared by the update");

  // Counters and events are clear right after reset
  property p_reset_clear;
    @(posedge clk)
    $fell(reset) |-> (event_line == 2'b00 && s_q.pcnt == '0 && s_q.ucnt == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared after reset");

  // Asynchronous channel 1 takes its period shadow at its own period end
  property p_async_apply;
    @(posedge clk) disable iff (reset)
    (!s_q.sync[1] && period_end[1] && s_q.per_pend[1] &&
     !(wr && wb_adr_i[11:8] == PAGE_CH)) |=> (s_q.per[1] == $past(s_q.per_sh[1]));
  endproperty
  a_async_apply: assert property (p_async_apply)
    else $error("async period shadow not applied");

  // Direct period write ignored while channel 1 runs
  property p_direct_blocked;
    @(posedge clk) disable iff (reset)
    (channel_enabled[1] && !period_end[1] && !period_end[0] && s_q.sync[1] == 1'b0 &&
     wr && wb_adr_i == 12'h320) |=> $stable(s_q.per[1]);
  endproperty
  a_direct_blocked: assert property (p_direct_blocked)
    else $error("active period changed by direct write");

  // Comparison period counter wraps at its maximum
  property p_period_wrap;
    @(posedge clk) disable iff (reset)
    (period_end[0] && s_q.pcnt[0] == s_q.cfg[0][CFG_PMAX +: 4]) |=> (s_q.pcnt[0] == 4'h0);
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("compare period counter did not wrap");
endmodule : pce_compare_update

// *** pce_wave_model.sv ***
`timescale 1ns/1ps
module pce_wave_model #(
  parameter int PER = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Run control from the bench
  input wire logic run,
  // Counter view seen by the block
  output logic [15:0] counter0,
  output logic [3:0] period_end
);
  // Left-aligned up counter; it holds while stopped so no period end leaks out
  always_ff @(posedge clk)
  begin
    if (reset || (run && counter0 == 16'(PER - 1)))
      counter0 <= 16'h0000;
    else if (run)
      counter0 <= counter0 + 16'h0001;
  end
  // One shared counter serves every synchronous channel
  assign period_end = {4{run && counter0 == 16'(PER - 1)}};
endmodule : pce_wave_model

// *** test_pwm_compare_event_update.sv ***
`timescale 1ns/1ps
module test_pwm_compare_event_update;
  import pce_pkg::*;
  // Bench drive and design outputs
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, run = 0, ack, irq;
  logic center = 0, down = 0, fault = 0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000, rd, dat_o;
  logic [15:0] cnt0;
  logic [3:0] pend, ch_en = 4'h0;
  logic [1:0] ev, ev_prev = 2'b00;
  logic [3:0][15:0] per_a, duty_a;
  logic [3:0][31:0] dt_a;
  int ev0 = 0, ev1 = 0, err_total = 0, compares = 0;

  always #12.5 clk = ~clk;

  pce_wave_model #(.PER(8)) i_wave (.clk(clk), .reset(reset), .run(run), .counter0(cnt0),
    .period_end(pend));

  pce_compare_update i_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .counter0(cnt0), .counter0_down(down), .alignment_center(center),
    .fault_ch0(fault), .channel_enabled(ch_en), .period_end(pend), .event_line(ev),
    .irq(irq), .period_active(per_a), .duty_active(duty_a), .deadtime_active(dt_a));

  // Count event pulses; a pulse longer than one clock is flagged at once
  always @(posedge clk)
  begin
    ev0 <= ev0 + int'(ev[0]);
    ev1 <= ev1 + int'(ev[1]);
    ev_prev <= ev;
    if ((ev & ev_prev) != 2'b00)
    begin
      err_total++;
      $display("MISMATCH event_width expected 1 seen 2");
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    // A slave that never answers ends the run here
    if (n >= 50)
    begin
      chk("wb_ack", 32'h1, 32'h0);
      test_done();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd & m);
  endtask : rdchk

  task automatic wait_per(input int n);
    repeat (n * 8) @(posedge clk);
  endtask : wait_per

  // Wait for n period ends seen by the block, then one edge more so the update has landed
  task automatic wait_end(input int n);
    repeat (n)
    begin
      @(posedge clk);
      while (pend[0] !== 1'b1)
        @(posedge clk);
    end
    @(posedge clk);
  endtask : wait_end

  function automatic logic [11:0] ca(input int u, input logic [1:0] k);
    return 12'h100 + 12'(u * 16) + 12'(int'(k) * 4);
  endfunction : ca

  function automatic logic [11:0] cha(input int c, input logic [2:0] k);
    return 12'h300 + 12'(c * 32) + 12'(int'(k) * 4);
  endfunction : cha

  // Pulses on both lines over eight counter periods
  task automatic evwin(input int e0, input int e1);
    int a0, a1;
    wait_per(1);
    @(posedge clk);
    a0 = ev0;
    a1 = ev1;
    wait_per(8);
    chk("event0_count", 32'(e0), 32'(ev0 - a0));
    chk("event1_count", 32'(e1), 32'(ev1 - a1));
  endtask : evwin

  task automatic test_done();
    $display("Compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic t_reset();
    rdchk("irq_status", OFS_IRQ_STAT, 32'hFFFF_FFFF, 32'h0);
    rdchk("cfg0", ca(0, CMP_CFG), 32'hFFFF_FFFF, 32'h0);
    rdchk("unmapped", 12'h7F0, 32'hFFFF_FFFF, 32'h0);
    chk("event_idle", 32'h0, 32'(ev));
  endtask : t_reset

  // Unit 2 on line 0 at 5 (down flag set), units 3 and 4 on line 1 at 2 and 6
  task automatic t_match();
    wb(1'b1, ca(2, CMP_CFG), 32'h0000_0001);
    wb(1'b1, ca(2, CMP_VAL), 32'h0100_0005);
    wb(1'b1, ca(3, CMP_CFG), 32'h0000_0001);
    wb(1'b1, ca(3, CMP_VAL), 32'h0000_0002);
    wb(1'b1, ca(4, CMP_CFG), 32'h0001_0101);
    wb(1'b1, ca(4, CMP_VAL), 32'h0000_0006);
    wb(1'b1, OFS_EVT0, 32'h0000_0004);
    wb(1'b1, OFS_EVT1, 32'h0000_0018);
    @(posedge clk) run <= 1'b1;
    evwin(8, 12);
    @(posedge clk) center <= 1'b1;
    evwin(0, 12);
    @(posedge clk) down <= 1'b1;
    evwin(8, 0);
    @(posedge clk) center <= 1'b0;
    down <= 1'b0;
    fault <= 1'b1;
    evwin(0, 0);
    @(posedge clk) fault <= 1'b0;
  endtask : t_match

  task automatic t_irq();
    wb(1'b1, OFS_IRQ_EN, 32'h0000_0004);
    @(posedge clk) run <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq_set", 32'h1, 32'(irq));
    rdchk("irq_mask", OFS_IRQ_MASK, 32'h0000_FFFF, 32'h0000_0004);
    rdchk("irq_status", OFS_IRQ_STAT, 32'h0000_FFFF, 32'h0000_001C);
    rdchk("irq_status_clr", OFS_IRQ_STAT, 32'h0000_FFFF, 32'h0);
    chk("irq_clr", 32'h0, 32'(irq));
    wb(1'b1, OFS_IRQ_DIS, 32'h0000_0004);
    rdchk("irq_mask_off", OFS_IRQ_MASK, 32'h0000_FFFF, 32'h0);
  endtask : t_irq

  task automatic t_shadow();
    @(posedge clk) run <= 1'b1;
    ch_en <= 4'h1;
    wb(1'b1, ca(2, CMP_CFG), 32'h0000_0000);
    rdchk("cfg_direct", ca(2, CMP_CFG), CFG_WMASK, 32'h0000_0001);
    wb(1'b1, ca(2, CMP_VAL_SH), 32'h0000_0003);
    wb(1'b1, ca(2, CMP_VAL_SH), 32'h0000_0006);
    wb(1'b1, ca(2, CMP_CFG_SH), 32'h0000_0001);
    wait_per(2);
    rdchk("val_update", ca(2, CMP_VAL), VAL_WMASK, 32'h0000_0006);
    rdchk("upd_flag", OFS_IRQ_STAT, 32'h0000_0400, 32'h0000_0400);
    wb(1'b1, ca(2, CMP_VAL_SH), 32'h0000_0009);
    wait_per(2);
    rdchk("val_alone", ca(2, CMP_VAL), VAL_WMASK, 32'h0000_0006);
    wb(1'b1, ca(2, CMP_CFG_SH), 32'h0100_0001);
    wait_per(2);
    rdchk("cfg_uper", ca(2, CMP_CFG), CFG_WMASK, 32'h0100_0001);
    rdchk("val_paired", ca(2, CMP_VAL), VAL_WMASK, 32'h0000_0009);
  endtask : t_shadow

  task automatic t_channel();
    wb(1'b1, cha(1, CH_PER), 32'h0000_0010);
    chk("per_direct", 32'h10, 32'(per_a[1]));
    @(posedge clk) ch_en <= 4'h3;
    wb(1'b1, cha(1, CH_PER), 32'h0000_0020);
    chk("per_locked", 32'h10, 32'(per_a[1]));
    wb(1'b1, cha(1, CH_PER_SH), 32'h0000_1111);
    wb(1'b1, cha(1, CH_PER_SH), 32'h0000_1234);
    wait_per(2);
    chk("per_async", 32'h1234, 32'(per_a[1]));
  endtask : t_channel

  task automatic t_sync();
    wb(1'b1, OFS_SYNC_MODE, 32'h0000_0004);
    @(posedge clk) ch_en <= 4'h7;
    wb(1'b1, cha(2, CH_DUTY_SH), 32'h0000_0042);
    wait_per(2);
    chk("duty_locked", 32'h0, 32'(duty_a[2]));
    @(posedge clk) run <= 1'b0;
    wb(1'b1, OFS_UPD_CTRL, 32'h0000_0001);
    rdchk("unlock_held", OFS_UPD_CTRL, 32'h1, 32'h1);
    @(posedge clk) run <= 1'b1;
    wait_per(2);
    rdchk("unlock_clr", OFS_UPD_CTRL, 32'h1, 32'h0);
    chk("duty_sync", 32'h42, 32'(duty_a[2]));
  endtask : t_sync

  // Method 1 on channel 2: duty follows the update period, dead-time waits for unlock
  task automatic t_auto();
    @(posedge clk) run <= 1'b0;
    wb(1'b1, OFS_SYNC_MODE, 32'h0001_0004);
    wb(1'b1, OFS_UPD_PER, 32'h0000_0003);
    wb(1'b1, OFS_UPD_PER_SH, 32'h0000_0001);
    wb(1'b1, cha(2, CH_DUTY_SH), 32'h0000_0055);
    wb(1'b1, cha(2, CH_DT_SH), 32'h0000_0077);
    @(posedge clk) run <= 1'b1;
    wait_end(3);
    chk("duty_early", 32'h42, 32'(duty_a[2]));
    wait_end(1);
    chk("duty_auto", 32'h55, 32'(duty_a[2]));
    chk("dt_locked", 32'h0, dt_a[2]);
    wb(1'b1, cha(2, CH_DUTY_SH), 32'h0000_0066);
    wait_end(1);
    chk("duty_upr_wait", 32'h55, 32'(duty_a[2]));
    wait_end(1);
    chk("duty_new_upr", 32'h66, 32'(duty_a[2]));
    wb(1'b1, OFS_UPD_CTRL, 32'h0000_0001);
    wait_end(1);
    chk("dt_unlocked", 32'h77, dt_a[2]);
  endtask : t_auto

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_match();
    t_irq();
    t_shadow();
    t_channel();
    t_sync();
    t_auto();
    test_done();
  end

  // Watchdog well beyond the expected run of about six hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("MISMATCH watchdog expected done seen timeout");
    test_done();
  end
endmodule : test_pwm_compare_event_update
